// ---- src/spc_regs.sv ----
`timescale 1ns/1ps
// What this block does
// - a boost enable bit set to 1 enables boost for that pll's pump
// - while boosting, pump current is forced to maximum
// - with its hold bit clear, boost ends on the second phase reversal after acquisition starts
// - with its hold bit clear, boost also ends as soon as frequency acquisition is reported
// - after boost, pump current returns to the programmed level
// - seven registers, each written by one 24-bit frame
// - low 4 frame bits are the address, upper 20 the data
// - unused data bits are ignored
// - while select is low, one bit shifts in per rising serial clock
// - select rising latches the frame into the addressed register
// - power-up loads the documented default of every register
// - addresses 0-5 and 7 select registers, others nothing
// - rf main and reference dividers drive the rf pll
// - if main and reference dividers drive the if pll
// - soft power-off bit 0 powers down all but the serial port
// - power-off pin low powers down all; both offs lose contents
// - standby bit 2 keeps all register contents
// - hold bit with boost enable keeps boost after acquisition
// - writing bit 0 low resets every register to default
// - standby bit low powers down all but registers and port
// - mode field bits 12:11 selects fm, cell, pcs high, pcs low
module spc_regs (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        serial_clk,
  input  wire logic        serial_cs_n,
  input  wire logic        serial_data,
  input  wire logic        power_off_pin_n,
  input  wire logic        rf_phase_lead,
  input  wire logic        if_phase_lead,
  input  wire logic        rf_freq_acquired,
  input  wire logic        if_freq_acquired,
  output logic [17:0]      rf_main_divider,
  output logic [12:0]      rf_reference_divider,
  output logic [13:0]      if_main_divider,
  output logic [10:0]      if_reference_divider,
  output logic [15:0]      operation_control,
  output logic [15:0]      pll_setup,
  output logic [7:0]       factory_check,
  output logic [2:0]       rf_pump_current_level,
  output logic [2:0]       if_pump_current_level,
  output logic             rf_boost_active,
  output logic             if_boost_active,
  output logic             core_power_on,
  output logic             bias_on,
  output logic             tx_path_on,
  output logic             rf_pll_on,
  output logic             if_pll_on,
  output logic [1:0]       operating_mode,
  output logic [2:0]       rf_port_select
);

  ////////////////////////////////////////////////////////////////////////
  // serial clock domain: shift register only

  logic [23:0] shift_reg;
  logic [23:0] shift_next;

  // runs only while select is low, so the word holds still once
  // select rises and the ref_clk side can read it without a handshake
  always_comb begin
    shift_next = shift_reg;
    if (!serial_cs_n) begin
      shift_next = {shift_reg[22:0], serial_data};
    end
  end

  always_ff @(posedge serial_clk) begin
    shift_reg <= shift_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers, three stages, change counted when 2 and 3 agree

  logic [5:0] sy1_reg;
  logic [5:0] sy2_reg;
  logic [5:0] sy3_reg;
  logic [5:0] settled_reg;
  logic [5:0] settled_next;
  logic [5:0] pins;

  assign pins = {if_freq_acquired, rf_freq_acquired,
                 if_phase_lead, rf_phase_lead,
                 power_off_pin_n, serial_cs_n};

  always_comb begin
    for (int k = 0; k < spc_pkg::SY_W; k++) begin
      settled_next[k] = (sy2_reg[k] == sy3_reg[k]) ? sy3_reg[k]
                                                   : settled_reg[k];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sy1_reg     <= spc_pkg::SY_RST;
      sy2_reg     <= spc_pkg::SY_RST;
      sy3_reg     <= spc_pkg::SY_RST;
      settled_reg <= spc_pkg::SY_RST;
    end else begin
      sy1_reg     <= pins;
      sy2_reg     <= sy1_reg;
      sy3_reg     <= sy2_reg;
      settled_reg <= settled_next;
    end
  end

  logic       cs_rise;
  logic       pin_ok;
  logic [1:0] reversal;
  logic [1:0] acquired;

  always_comb begin
    cs_rise = settled_next[spc_pkg::SY_CS]
              && !settled_reg[spc_pkg::SY_CS];
    pin_ok  = settled_reg[spc_pkg::SY_PIN];
    for (int k = 0; k < 2; k++) begin
      reversal[k] = settled_next[spc_pkg::SY_PH + k]
                    != settled_reg[spc_pkg::SY_PH + k];
      acquired[k] = settled_reg[spc_pkg::SY_ACQ + k];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bank

  logic [17:0] rf_main_reg;
  logic [17:0] rf_main_next;
  logic [12:0] rf_ref_reg;
  logic [12:0] rf_ref_next;
  logic [13:0] if_main_reg;
  logic [13:0] if_main_next;
  logic [10:0] if_ref_reg;
  logic [10:0] if_ref_next;
  logic [15:0] opctl_reg;
  logic [15:0] opctl_next;
  logic [15:0] setup_reg;
  logic [15:0] setup_next;
  logic [7:0]  fcheck_reg;
  logic [7:0]  fcheck_next;
  logic        soft_off_reg;
  logic        soft_off_next;
  logic [1:0]  start_reg;
  logic [1:0]  start_next;
  logic [3:0]  addr;
  logic [19:0] data;
  logic        latch;

  always_comb begin
    rf_main_next  = rf_main_reg;
    rf_ref_next   = rf_ref_reg;
    if_main_next  = if_main_reg;
    if_ref_next   = if_ref_reg;
    opctl_next    = opctl_reg;
    setup_next    = setup_reg;
    fcheck_next   = fcheck_reg;
    soft_off_next = soft_off_reg;
    start_next    = 2'h0;
    addr  = shift_reg[spc_pkg::ADDR_W-1:0];
    data  = shift_reg[spc_pkg::FRAME_W-1:spc_pkg::DATA_LSB];
    latch = cs_rise && pin_ok;
    if (!pin_ok) begin
      // pin off kills the whole part, contents included
      rf_main_next  = spc_pkg::RF_MAIN_RST;
      rf_ref_next   = spc_pkg::RF_REF_RST;
      if_main_next  = spc_pkg::IF_MAIN_RST;
      if_ref_next   = spc_pkg::IF_REF_RST;
      opctl_next    = spc_pkg::OPCTL_RST;
      setup_next    = spc_pkg::SETUP_RST;
      fcheck_next   = spc_pkg::FCHECK_RST;
      soft_off_next = 1'b0;
    end else if (latch) begin
      // upper unused bits dropped by the part-selects
      if (addr == spc_pkg::ADDR_RF_MAIN) begin
        rf_main_next = data[spc_pkg::RF_MAIN_W-1:0];
        start_next[0] = 1'b1;
      end else if (addr == spc_pkg::ADDR_RF_REF) begin
        rf_ref_next = data[spc_pkg::RF_REF_W-1:0];
        start_next[0] = 1'b1;
      end else if (addr == spc_pkg::ADDR_IF_MAIN) begin
        if_main_next = data[spc_pkg::IF_MAIN_W-1:0];
        start_next[1] = 1'b1;
      end else if (addr == spc_pkg::ADDR_IF_REF) begin
        if_ref_next = data[spc_pkg::IF_REF_W-1:0];
        start_next[1] = 1'b1;
      end else if (addr == spc_pkg::ADDR_OPCTL) begin
        if (!data[spc_pkg::OPC_SOFT_OFF_N]) begin
          // soft off: defaults everywhere, part stays off until a
          // control write with bit 0 high or a power-off pin cycle
          rf_main_next  = spc_pkg::RF_MAIN_RST;
          rf_ref_next   = spc_pkg::RF_REF_RST;
          if_main_next  = spc_pkg::IF_MAIN_RST;
          if_ref_next   = spc_pkg::IF_REF_RST;
          opctl_next    = spc_pkg::OPCTL_RST;
          setup_next    = spc_pkg::SETUP_RST;
          fcheck_next   = spc_pkg::FCHECK_RST;
          soft_off_next = 1'b1;
        end else begin
          opctl_next    = data[spc_pkg::OPCTL_W-1:0];
          soft_off_next = 1'b0;
        end
      end else if (addr == spc_pkg::ADDR_SETUP) begin
        setup_next = data[spc_pkg::SETUP_W-1:0];
        start_next[0] = data[spc_pkg::SET_RF_BOOST_EN];
        start_next[1] = data[spc_pkg::SET_IF_BOOST_EN];
      end else if (addr == spc_pkg::ADDR_FCHECK) begin
        fcheck_next = data[spc_pkg::FCHECK_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rf_main_reg  <= spc_pkg::RF_MAIN_RST;
      rf_ref_reg   <= spc_pkg::RF_REF_RST;
      if_main_reg  <= spc_pkg::IF_MAIN_RST;
      if_ref_reg   <= spc_pkg::IF_REF_RST;
      opctl_reg    <= spc_pkg::OPCTL_RST;
      setup_reg    <= spc_pkg::SETUP_RST;
      fcheck_reg   <= spc_pkg::FCHECK_RST;
      soft_off_reg <= 1'b0;
      start_reg    <= 2'h0;
    end else begin
      rf_main_reg  <= rf_main_next;
      rf_ref_reg   <= rf_ref_next;
      if_main_reg  <= if_main_next;
      if_ref_reg   <= if_ref_next;
      opctl_reg    <= opctl_next;
      setup_reg    <= setup_next;
      fcheck_reg   <= fcheck_next;
      soft_off_reg <= soft_off_next;
      start_reg    <= start_next;
    end
  end

  assign rf_main_divider      = rf_main_reg;
  assign rf_reference_divider = rf_ref_reg;
  assign if_main_divider      = if_main_reg;
  assign if_reference_divider = if_ref_reg;
  assign operation_control    = opctl_reg;
  assign pll_setup            = setup_reg;
  assign factory_check        = fcheck_reg;

  ////////////////////////////////////////////////////////////////////////
  // power and mode outputs

  logic       core_reg;
  logic       core_next;
  logic       bias_reg;
  logic       bias_next;
  logic       tx_reg;
  logic       tx_next;
  logic [1:0] pll_on_reg;
  logic [1:0] pll_on_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [2:0] port_reg;
  logic [2:0] port_next;

  always_comb begin
    core_next = pin_ok && !soft_off_next;
    // standby only gates analog power, registers keep their values
    bias_next = core_next
                && opctl_next[spc_pkg::OPC_STANDBY_N];
    tx_next   = bias_next && opctl_next[spc_pkg::OPC_TX_STANDBY_N_N];
    pll_on_next[0] = bias_next && setup_next[spc_pkg::SET_RF_PLL_ON];
    pll_on_next[1] = bias_next && setup_next[spc_pkg::SET_IF_PLL_ON];
    mode_next = opctl_next[spc_pkg::OPC_MODE_LSB +: 2];
    case (mode_next)
      spc_pkg::MODE_PCS_HIGH: port_next = spc_pkg::PORT_HIGH1;
      spc_pkg::MODE_PCS_LOW:  port_next = spc_pkg::PORT_HIGH0;
      default:                port_next = spc_pkg::PORT_LOW;
    endcase
    if (!tx_next) begin
      port_next = 3'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      core_reg   <= 1'b0;
      bias_reg   <= 1'b0;
      tx_reg     <= 1'b0;
      pll_on_reg <= 2'h0;
      mode_reg   <= spc_pkg::MODE_CELL;
      port_reg   <= 3'h0;
    end else begin
      core_reg   <= core_next;
      bias_reg   <= bias_next;
      tx_reg     <= tx_next;
      pll_on_reg <= pll_on_next;
      mode_reg   <= mode_next;
      port_reg   <= port_next;
    end
  end

  assign core_power_on  = core_reg;
  assign bias_on        = bias_reg;
  assign tx_path_on     = tx_reg;
  assign rf_pll_on      = pll_on_reg[0];
  assign if_pll_on      = pll_on_reg[1];
  assign operating_mode = mode_reg;
  assign rf_port_select = port_reg;

  ////////////////////////////////////////////////////////////////////////
  // charge pump boost, index 0 rf, 1 if

  spc_pkg::spc_boost_t bst_reg  [2];
  spc_pkg::spc_boost_t bst_next [2];
  logic [1:0] rev_reg  [2];
  logic [1:0] rev_next [2];
  logic [2:0] cur_reg  [2];
  logic [2:0] cur_next [2];
  logic [1:0] boost_en;
  logic [1:0] hold;
  logic [2:0] level [2];

  always_comb begin
    boost_en[0] = setup_reg[spc_pkg::SET_RF_BOOST_EN];
    boost_en[1] = setup_reg[spc_pkg::SET_IF_BOOST_EN];
    hold[0]  = opctl_reg[spc_pkg::OPC_RF_HOLD];
    hold[1]  = opctl_reg[spc_pkg::OPC_IF_HOLD];
    level[0] = setup_reg[spc_pkg::SET_RF_CUR_LSB +: spc_pkg::CUR_W];
    level[1] = setup_reg[spc_pkg::SET_IF_CUR_LSB +: spc_pkg::CUR_W];
    for (int i = 0; i < 2; i++) begin
      bst_next[i] = bst_reg[i];
      rev_next[i] = rev_reg[i];
      case (bst_reg[i])
        spc_pkg::BST_IDLE: begin
          if (start_reg[i] && boost_en[i] && pll_on_reg[i]) begin
            bst_next[i] = spc_pkg::BST_ACTIVE;
            rev_next[i] = 2'h0;
          end
        end
        spc_pkg::BST_ACTIVE: begin
          if (!boost_en[i] || !pll_on_reg[i]) begin
            bst_next[i] = spc_pkg::BST_IDLE;
          end else if (start_reg[i]) begin
            rev_next[i] = 2'h0;
          end else if (hold[i]) begin
            bst_next[i] = spc_pkg::BST_ACTIVE;
          end else if (acquired[i]) begin
            bst_next[i] = spc_pkg::BST_IDLE;
          end else if (reversal[i]) begin
            rev_next[i] = 2'(rev_reg[i] + 2'h1);
            if (rev_next[i] == spc_pkg::REVERSALS_TO_END) begin
              bst_next[i] = spc_pkg::BST_IDLE;
            end
          end
        end
        default: begin
          bst_next[i] = spc_pkg::BST_IDLE;
          rev_next[i] = 2'h0;
        end
      endcase
      if (bst_next[i] == spc_pkg::BST_ACTIVE) begin
        cur_next[i] = spc_pkg::CUR_MAX;
      end else begin
        cur_next[i] = level[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (reset) begin
        bst_reg[i] <= spc_pkg::BST_IDLE;
        rev_reg[i] <= 2'h0;
        cur_reg[i] <= 3'h0;
      end else begin
        bst_reg[i] <= bst_next[i];
        rev_reg[i] <= rev_next[i];
        cur_reg[i] <= cur_next[i];
      end
    end
  end

  // boost flag tracks the state flop one-hot bit directly
  assign rf_boost_active       = bst_reg[0][1];
  assign if_boost_active       = bst_reg[1][1];
  assign rf_pump_current_level = cur_reg[0];
  assign if_pump_current_level = cur_reg[1];

endmodule

// ---- src/spc_pkg.sv ----
package spc_pkg;

  // serial frame layout
  localparam int FRAME_W = 24;
  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 20;
  localparam int DATA_LSB = 4;

  // register addresses
  localparam logic [3:0] ADDR_RF_MAIN = 4'h0;
  localparam logic [3:0] ADDR_RF_REF  = 4'h1;
  localparam logic [3:0] ADDR_IF_MAIN = 4'h2;
  localparam logic [3:0] ADDR_IF_REF  = 4'h3;
  localparam logic [3:0] ADDR_OPCTL   = 4'h4;
  localparam logic [3:0] ADDR_SETUP   = 4'h5;
  localparam logic [3:0] ADDR_FCHECK  = 4'h7;

  // used widths of each register
  localparam int RF_MAIN_W = 18;
  localparam int RF_REF_W  = 13;
  localparam int IF_MAIN_W = 14;
  localparam int IF_REF_W  = 11;
  localparam int OPCTL_W   = 16;
  localparam int SETUP_W   = 16;
  localparam int FCHECK_W  = 8;

  // power-up values
  localparam logic [17:0] RF_MAIN_RST = 18'h2A037;
  localparam logic [12:0] RF_REF_RST  = 13'h07B0;
  localparam logic [13:0] IF_MAIN_RST = 14'h1977;
  localparam logic [10:0] IF_REF_RST  = 11'h1EC;
  localparam logic [15:0] OPCTL_RST   = 16'h892F;
  localparam logic [15:0] SETUP_RST   = 16'hD03F;
  localparam logic [7:0]  FCHECK_RST  = 8'h00;

  // operation control fields
  localparam int OPC_SOFT_OFF_N = 0;
  localparam int OPC_TX_STANDBY_N_N  = 1;
  localparam int OPC_STANDBY_N  = 2;
  localparam int OPC_MODE_LSB   = 11;
  localparam int OPC_IF_HOLD    = 13;
  localparam int OPC_RF_HOLD    = 14;

  // pll setup fields
  localparam int SET_IF_PLL_ON   = 15;
  localparam int SET_RF_PLL_ON   = 14;
  localparam int SET_RF_BOOST_EN = 9;
  localparam int SET_IF_BOOST_EN = 8;
  localparam int SET_RF_CUR_LSB  = 3;
  localparam int SET_IF_CUR_LSB  = 0;
  localparam int CUR_W           = 3;
  localparam logic [2:0] CUR_MAX = 3'h7;

  // boost ends on this many phase reversals
  localparam logic [1:0] REVERSALS_TO_END = 2'h2;

  // operating modes
  localparam logic [1:0] MODE_FM       = 2'h0;
  localparam logic [1:0] MODE_CELL     = 2'h1;
  localparam logic [1:0] MODE_PCS_HIGH = 2'h2;
  localparam logic [1:0] MODE_PCS_LOW  = 2'h3;

  // rf output port one-hot: low band, high 0, high 1
  localparam logic [2:0] PORT_LOW   = 3'h1;
  localparam logic [2:0] PORT_HIGH0 = 3'h2;
  localparam logic [2:0] PORT_HIGH1 = 3'h4;

  // synchroniser lanes
  localparam int SY_CS   = 0;
  localparam int SY_PIN  = 1;
  localparam int SY_PH   = 2;
  localparam int SY_ACQ  = 4;
  localparam int SY_W    = 6;
  localparam logic [5:0] SY_RST = 6'h03;

  typedef enum logic [1:0] {
    BST_IDLE   = 2'b01,
    BST_ACTIVE = 2'b10
  } spc_boost_t;

endpackage

// ---- testbench/spc_regs_props.sv ----
`timescale 1ns/1ps
module spc_regs_props (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        rf_freq_acquired,
  input wire logic [17:0] rf_main_divider,
  input wire logic [15:0] operation_control,
  input wire logic [15:0] pll_setup,
  input wire logic [7:0]  factory_check,
  input wire logic [2:0]  rf_pump_current_level,
  input wire logic        rf_boost_active,
  input wire logic        core_power_on,
  input wire logic        bias_on,
  input wire logic        tx_path_on,
  input wire logic        rf_pll_on,
  input wire logic [1:0]  operating_mode,
  input wire logic [2:0]  rf_port_select
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  function automatic logic [2:0] port_of(input logic [1:0] m);
    return (m == spc_pkg::MODE_PCS_HIGH) ? spc_pkg::PORT_HIGH1 :
           (m == spc_pkg::MODE_PCS_LOW) ? spc_pkg::PORT_HIGH0 :
           spc_pkg::PORT_LOW;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  a_boost_pump_max: assert property (
    rf_boost_active [*2] |-> rf_pump_current_level == spc_pkg::CUR_MAX
  ) else $error("boost pump not at maximum");
  // two quiet cycles absorb the register stage behind the pump output
  a_pump_back_level: assert property (
    (!rf_boost_active && core_power_on && $stable(pll_setup)) [*2]
    |-> rf_pump_current_level == pll_setup[5:3]
  ) else $error("pump not at programmed level");
  a_mode_follows: assert property (
    (core_power_on && $stable(operation_control)) [*2]
    |-> operating_mode == operation_control[12:11]
  ) else $error("mode differs from control field");
  a_port_steering: assert property (
    rf_port_select == (tx_path_on ? port_of(operating_mode) : 3'h0)
  ) else $error("output port select wrong");
  a_bias_standby: assert property (
    $stable(operation_control) && $stable(core_power_on)
    |-> bias_on == (core_power_on && operation_control[2])
  ) else $error("bias does not follow standby");
  a_tx_path_gate: assert property (
    $stable(operation_control) && $stable(bias_on)
    |-> tx_path_on == (bias_on && operation_control[1])
  ) else $error("tx path gate wrong");
  a_rf_pll_gate: assert property (
    $stable(pll_setup) && $stable(bias_on)
    |-> rf_pll_on == (bias_on && pll_setup[14])
  ) else $error("rf pll enable wrong");
  a_boost_needs_en: assert property (
    !pll_setup[9] [*3] |-> !rf_boost_active
  ) else $error("boost without enable");
  a_lock_ends_boost: assert property (
    (rf_freq_acquired && !operation_control[14]) [*6] |-> !rf_boost_active
  ) else $error("boost kept after lock");
  a_off_defaults: assert property (
    $fell(core_power_on) |-> ##[0:1]
    (rf_main_divider == spc_pkg::RF_MAIN_RST &&
     pll_setup == spc_pkg::SETUP_RST && factory_check == spc_pkg::FCHECK_RST)
  ) else $error("power off kept register contents");

  c_boost_seen: cover property ($rose(rf_boost_active));
  c_power_off: cover property ($fell(core_power_on));
  c_high1_port: cover property (rf_port_select == spc_pkg::PORT_HIGH1);
endmodule

bind spc_regs spc_regs_props spc_regs_props_i (
  .ref_clk(ref_clk), .reset(reset), .rf_freq_acquired(rf_freq_acquired),
  .rf_main_divider(rf_main_divider), .operation_control(operation_control),
  .pll_setup(pll_setup), .factory_check(factory_check),
  .rf_pump_current_level(rf_pump_current_level),
  .rf_boost_active(rf_boost_active), .core_power_on(core_power_on),
  .bias_on(bias_on), .tx_path_on(tx_path_on), .rf_pll_on(rf_pll_on),
  .operating_mode(operating_mode), .rf_port_select(rf_port_select)
);

// ---- testbench/spc_host_model.sv ----
`timescale 1ns/1ps
module spc_host_model (
  output logic serial_clk,
  output logic serial_cs_n,
  output logic serial_data
);
  initial begin
    serial_clk  = 1'b0;
    serial_cs_n = 1'b1;
    serial_data = 1'b0;
  end

  // link clock runs only inside a frame, 12 ns period
  task automatic send(input logic [23:0] frame);
    serial_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      serial_data = frame[i];
      #6 serial_clk = 1'b1;
      #6 serial_clk = 1'b0;
    end
    // released line shows the inverse, never a stale value
    serial_data = ~frame[0];
    #6 serial_cs_n = 1'b1;
  endtask
endmodule

// ---- testbench/spc_regs_tb_top.sv ----
`timescale 1ns/1ps
module spc_regs_tb_top;
  logic        ref_clk;
  logic        reset;
  logic        serial_clk;
  logic        serial_cs_n;
  logic        serial_data;
  logic        power_off_pin_n;
  logic        rf_phase_lead;
  logic        if_phase_lead;
  logic        rf_freq_acquired;
  logic        if_freq_acquired;
  logic [17:0] rf_main_divider;
  logic [12:0] rf_reference_divider;
  logic [13:0] if_main_divider;
  logic [10:0] if_reference_divider;
  logic [15:0] operation_control;
  logic [15:0] pll_setup;
  logic [7:0]  factory_check;
  logic [2:0]  rf_pump_current_level;
  logic [2:0]  if_pump_current_level;
  logic        rf_boost_active;
  logic        if_boost_active;
  logic        core_power_on;
  logic        bias_on;
  logic        tx_path_on;
  logic        rf_pll_on;
  logic        if_pll_on;
  logic [1:0]  operating_mode;
  logic [2:0]  rf_port_select;
  int          bad_count;
  int          compares;

  localparam logic [3:0]  ADR [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
    4'h7};
  localparam logic [19:0] DEF [7] = '{20'h2A037, 20'h007B0, 20'h01977,
    20'h001EC, 20'h0892F, 20'h0D03F, 20'h00000};
  localparam logic [19:0] WRV [7] = '{20'hEA5C3, 20'hFF0F1, 20'hC3333,
    20'hFF5A5, 20'hF8127, 20'hFC012, 20'hFFF3C};
  localparam logic [19:0] EXV [7] = '{20'h2A5C3, 20'h010F1, 20'h03333,
    20'h005A5, 20'h08127, 20'h0C012, 20'h0003C};
  localparam logic [2:0]  PRT [4] = '{spc_pkg::PORT_LOW, spc_pkg::PORT_LOW,
    spc_pkg::PORT_HIGH1, spc_pkg::PORT_HIGH0};

  spc_host_model spc_host_model_i (
    .serial_clk (serial_clk),
    .serial_cs_n(serial_cs_n),
    .serial_data(serial_data)
  );

  spc_regs spc_regs_i (
    .ref_clk(ref_clk), .reset(reset), .serial_clk(serial_clk),
    .serial_cs_n(serial_cs_n), .serial_data(serial_data),
    .power_off_pin_n(power_off_pin_n), .rf_phase_lead(rf_phase_lead),
    .if_phase_lead(if_phase_lead), .rf_freq_acquired(rf_freq_acquired),
    .if_freq_acquired(if_freq_acquired), .rf_main_divider(rf_main_divider),
    .rf_reference_divider(rf_reference_divider),
    .if_main_divider(if_main_divider),
    .if_reference_divider(if_reference_divider),
    .operation_control(operation_control), .pll_setup(pll_setup),
    .factory_check(factory_check),
    .rf_pump_current_level(rf_pump_current_level),
    .if_pump_current_level(if_pump_current_level),
    .rf_boost_active(rf_boost_active), .if_boost_active(if_boost_active),
    .core_power_on(core_power_on), .bias_on(bias_on),
    .tx_path_on(tx_path_on), .rf_pll_on(rf_pll_on), .if_pll_on(if_pll_on),
    .operating_mode(operating_mode), .rf_port_select(rf_port_select)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [19:0] view(input logic [3:0] a);
    case (a)
      4'h0: view = {2'h0, rf_main_divider};
      4'h1: view = {7'h00, rf_reference_divider};
      4'h2: view = {6'h00, if_main_divider};
      4'h3: view = {9'h000, if_reference_divider};
      4'h4: view = {4'h0, operation_control};
      4'h5: view = {4'h0, pll_setup};
      default: view = {12'h000, factory_check};
    endcase
  endfunction

  task automatic chk(input string what, input logic [19:0] seen,
                     input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // 12 cycles covers the sync latency and the register and boost stages after it
  task automatic settle();
    repeat (12) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [19:0] d);
    spc_host_model_i.send({d, a});
    settle();
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    power_off_pin_n = 1'b1;
    rf_phase_lead = 1'b0;
    if_phase_lead = 1'b0;
    rf_freq_acquired = 1'b0;
    if_freq_acquired = 1'b0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    settle();
    for (int i = 0; i < 7; i++) chk("default", view(ADR[i]), DEF[i]);
    for (int i = 0; i < 7; i++) begin
      wr(ADR[i], WRV[i]);
      chk("written", view(ADR[i]), EXV[i]);
    end
    wr(4'h6, 20'h00000);
    wr(4'hF, 20'h00000);
    for (int i = 0; i < 7; i++) chk("kept", view(ADR[i]), EXV[i]);
    for (int i = 0; i < 4; i++) begin
      wr(4'h4, 20'h08127 | (20'(i) << 11));
      chk("mode", 20'(operating_mode), 20'(i));
      chk("port", 20'(rf_port_select), 20'(PRT[i]));
    end
    wr(4'h4, 20'h08123);
    chk("bias", 20'(bias_on), 20'h0);
    chk("rf pll on", 20'(rf_pll_on), 20'h0);
    chk("standby keeps", view(4'h0), EXV[0]);
    chk("tx off", 20'(tx_path_on), 20'h0);
    chk("if pll on", 20'(if_pll_on), 20'h0);
    wr(4'h4, 20'h08125);
    chk("tx gated", 20'(tx_path_on), 20'h0);
    chk("tx port", 20'(rf_port_select), 20'h0);
    chk("bias kept", 20'(bias_on), 20'h1);
    wr(4'h4, 20'h08127);
    wr(4'h5, 20'h0C215);
    chk("rf boost", 20'(rf_boost_active), 20'h1);
    chk("rf pump", 20'(rf_pump_current_level), 20'h7);
    chk("if pump", 20'(if_pump_current_level), 20'h5);
    @(posedge ref_clk) rf_phase_lead <= 1'b1;
    settle();
    chk("one reversal", 20'(rf_boost_active), 20'h1);
    @(posedge ref_clk) rf_phase_lead <= 1'b0;
    settle();
    chk("two reversals", 20'(rf_boost_active), 20'h0);
    chk("rf pump back", 20'(rf_pump_current_level), 20'h2);
    wr(4'h0, 20'h00100);
    chk("rf restart", 20'(rf_boost_active), 20'h1);
    @(posedge ref_clk) rf_freq_acquired <= 1'b1;
    settle();
    chk("rf lock end", 20'(rf_boost_active), 20'h0);
    @(posedge ref_clk) rf_freq_acquired <= 1'b0;
    wr(4'h4, 20'h0C127);
    wr(4'h0, 20'h00100);
    @(posedge ref_clk) rf_freq_acquired <= 1'b1;
    settle();
    chk("rf hold", 20'(rf_boost_active), 20'h1);
    @(posedge ref_clk) rf_freq_acquired <= 1'b0;
    wr(4'h4, 20'h0A127);
    wr(4'h5, 20'h0C115);
    chk("if boost", 20'(if_boost_active), 20'h1);
    chk("if pll up", 20'(if_pll_on), 20'h1);
    chk("tx on", 20'(tx_path_on), 20'h1);
    @(posedge ref_clk) if_freq_acquired <= 1'b1;
    if_phase_lead <= 1'b1;
    settle();
    @(posedge ref_clk) if_phase_lead <= 1'b0;
    settle();
    chk("if hold", 20'(if_boost_active), 20'h1);
    chk("if pump max", 20'(if_pump_current_level), 20'h7);
    @(posedge ref_clk) if_freq_acquired <= 1'b0;
    wr(4'h5, 20'h0C015);
    chk("if boost off", 20'(if_boost_active), 20'h0);
    chk("if pump back", 20'(if_pump_current_level), 20'h5);
    wr(4'h4, 20'h08126);
    chk("soft off", 20'(core_power_on), 20'h0);
    chk("soft dflt", view(4'h0), DEF[0]);
    chk("soft dflt setup", view(4'h5), DEF[5]);
    wr(4'h4, 20'h0892F);
    chk("soft on", 20'(core_power_on), 20'h1);
    wr(4'h7, 20'h0003C);
    @(posedge ref_clk) power_off_pin_n <= 1'b0;
    settle();
    chk("pin off", 20'(core_power_on), 20'h0);
    chk("pin lost", view(4'h7), DEF[6]);
    wr(4'h7, 20'h00055);
    @(posedge ref_clk) power_off_pin_n <= 1'b1;
    settle();
    chk("pin frame", view(4'h7), DEF[6]);
    chk("pin on", 20'(core_power_on), 20'h1);
    conclude();
  end
endmodule
